// ===== hdl/edge_irq_pkg.sv
// constants for the pin edge interrupt handler
package edge_irq_pkg;
	// ========================================
	// register offsets
	localparam logic [7:0] OFS_STATUS_LO  = 8'hB1;
	localparam logic [7:0] OFS_STATUS_HI  = 8'hB2;
	localparam logic [7:0] OFS_MASK_LO    = 8'hB4;
	localparam logic [7:0] OFS_MASK_HI    = 8'hB5;
	localparam logic [7:0] OFS_EDGE_0_3   = 8'hC0;
	localparam logic [7:0] OFS_EDGE_4_5   = 8'hC1;
	localparam logic [7:0] OFS_EDGE_9_11  = 8'hC2;
	localparam logic [7:0] OFS_EDGE_12_14 = 8'hC3;
	localparam logic [7:0] OFS_CTRL       = 8'hC5;
	// ========================================
	// fields and reset values
	localparam int         CTRL_RDCLR_BIT = 2;
	localparam int         CTRL_PEND_BIT  = 1;
	localparam logic [7:0] EDGE_RESET     = 8'h00;
	localparam logic [7:0] MASK_RESET     = 8'hFF;
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;
	// pins 0-5, 9-12 and 14 exist; all other pairs are inert
	localparam logic [15:0] PIN_VALID     = 16'h5E3F;
	localparam int         PIN_COUNT      = 16;
endpackage : edge_irq_pkg

// ===== hdl/pin_edge_detect.sv
// one pin: synchroniser, settled level and edge pulse
`timescale 1ns/1ps
module pin_edge_detect (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pin_async,
	input  wire logic is_input,
	input  wire logic rise_en,
	input  wire logic fall_en,
	output logic      edge_pulse
);
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic level_r;
	logic settled_change;

	// ========================================
	// synchroniser; first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= pin_async;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// change counts once the second and third stages agree
	assign settled_change = (sync2_r == sync3_r) && (sync3_r != level_r);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			level_r <= 1'b0;
		end else if (settled_change) begin
			level_r <= sync3_r;
		end
	end

	// ========================================
	// edge qualification
	always_comb begin
		edge_pulse = 1'b0;
		if (settled_change && is_input) begin
			edge_pulse = (sync3_r && rise_en) || (!sync3_r && fall_en);
		end
	end
endmodule : pin_edge_detect

// ===== hdl/edge_irq_handler.sv
// pin edge interrupt handler: edge select, mask, status, control
// What this block does
// - each pin picks falling edges with pattern 01, rising with 10, and both with 11.
// - with both selection bits clear a pin detects nothing, and that is the reset state.
// - only pins configured as inputs can raise edge events.
// - the upper bit of each pin's pair enables rising-edge detection.
// - the lower bit of each pair enables falling-edge detection; reserved pairs do nothing.
// - a mask bit at 1 blocks its pin from the request line, and all masks reset to 1.
// - a mask bit at 0 lets its pin's event reach the request line.
// - with pending-disable set, events arriving while the request is active are dropped.
// - with clear-on-read off, a write of 1 clears that status bit and reads change nothing.
// - with clear-on-read on, reading a status register clears it.
// - a clear-on-read access releases the request line once no unmasked status remains.
// - any unmasked detected event pulls the active-low request line low.
`timescale 1ns/1ps
module edge_irq_handler
	import edge_irq_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [15:0] pin_in,
	input  wire logic [15:0] pin_is_input,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             proc1_irq_n
);
	logic [7:0]  edge_sel_r [4];
	logic [7:0]  mask_r     [2];
	logic [15:0] status_r;
	logic        clear_on_read_select_r;
	logic        pending_event_disable_r;
	logic [7:0]  reg_rdata_r;
	logic        irq_n_r;
	logic [15:0] mask_all;
	logic [15:0] rise_en;
	logic [15:0] fall_en;
	logic [15:0] pin_event;
	logic [15:0] latch_set;
	logic [15:0] status_clr;
	logic [15:0] status_nxt;
	logic        wr_status_lo;
	logic        wr_status_hi;
	logic        rd_status_lo;
	logic        rd_status_hi;

	assign mask_all = {mask_r[1], mask_r[0]};

	// ========================================
	// per-pin edge detectors
	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : g_pin
			assign rise_en[p] = edge_sel_r[p / 4][2 * (p % 4) + 1];
			assign fall_en[p] = edge_sel_r[p / 4][2 * (p % 4)];
			pin_edge_detect u_det (
				.sys_clk    (sys_clk),
				.rst        (rst),
				.pin_async  (pin_in[p]),
				.is_input   (pin_is_input[p]),
				.rise_en    (rise_en[p]),
				.fall_en    (fall_en[p]),
				.edge_pulse (pin_event[p])
			);
		end
	endgenerate

	// ========================================
	// event latching and clearing
	always_comb begin
		latch_set = pin_event & PIN_VALID;
		// dropping events while serviced trades completeness for fewer re-entries
		if (pending_event_disable_r && !irq_n_r) begin
			latch_set = 16'h0000;
		end
	end

	assign wr_status_lo = reg_wr && (reg_addr == OFS_STATUS_LO);
	assign wr_status_hi = reg_wr && (reg_addr == OFS_STATUS_HI);
	assign rd_status_lo = reg_rd && (reg_addr == OFS_STATUS_LO);
	assign rd_status_hi = reg_rd && (reg_addr == OFS_STATUS_HI);

	always_comb begin
		status_clr = 16'h0000;
		if (clear_on_read_select_r) begin
			if (rd_status_lo) begin
				status_clr[7:0] = 8'hFF;
			end
			if (rd_status_hi) begin
				status_clr[15:8] = 8'hFF;
			end
		end else begin
			if (wr_status_lo) begin
				status_clr[7:0] = reg_wdata;
			end
			if (wr_status_hi) begin
				status_clr[15:8] = reg_wdata;
			end
		end
		// a new event beats a clear in the same cycle
		status_nxt = (status_r & ~status_clr) | latch_set;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_r <= {STATUS_RESET, STATUS_RESET};
		end else begin
			status_r <= status_nxt;
		end
	end

	// ========================================
	// request line, one cycle behind status
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= ~|(status_r & ~mask_all);
		end
	end

	assign proc1_irq_n = irq_n_r;

	// ========================================
	// configuration registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				edge_sel_r[i] <= EDGE_RESET;
			end
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_EDGE_0_3:   edge_sel_r[0] <= reg_wdata;
				OFS_EDGE_4_5:   edge_sel_r[1] <= reg_wdata;
				OFS_EDGE_9_11:  edge_sel_r[2] <= reg_wdata;
				OFS_EDGE_12_14: edge_sel_r[3] <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mask_r[0] <= MASK_RESET;
			mask_r[1] <= MASK_RESET;
		end else if (reg_wr && (reg_addr == OFS_MASK_LO)) begin
			mask_r[0] <= reg_wdata;
		end else if (reg_wr && (reg_addr == OFS_MASK_HI)) begin
			mask_r[1] <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clear_on_read_select_r  <= 1'b0;
			pending_event_disable_r <= 1'b0;
		end else if (reg_wr && (reg_addr == OFS_CTRL)) begin
			// other bits are not stored at all
			clear_on_read_select_r  <= reg_wdata[CTRL_RDCLR_BIT];
			pending_event_disable_r <= reg_wdata[CTRL_PEND_BIT];
		end
	end

	// ========================================
	// read port, data one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_r <= READ_UNMAPPED;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_STATUS_LO:  reg_rdata_r <= status_r[7:0];
				OFS_STATUS_HI:  reg_rdata_r <= status_r[15:8];
				OFS_MASK_LO:    reg_rdata_r <= mask_r[0];
				OFS_MASK_HI:    reg_rdata_r <= mask_r[1];
				OFS_EDGE_0_3:   reg_rdata_r <= edge_sel_r[0];
				OFS_EDGE_4_5:   reg_rdata_r <= edge_sel_r[1];
				OFS_EDGE_9_11:  reg_rdata_r <= edge_sel_r[2];
				OFS_EDGE_12_14: reg_rdata_r <= edge_sel_r[3];
				OFS_CTRL: begin
					reg_rdata_r <= 8'h00;
					reg_rdata_r[CTRL_RDCLR_BIT] <= clear_on_read_select_r;
					reg_rdata_r[CTRL_PEND_BIT] <= pending_event_disable_r;
				end
				default:        reg_rdata_r <= READ_UNMAPPED;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_r;

	// ========================================
	// checks
	edge_gated_a: assert property (@(posedge sys_clk) disable iff (rst)
		|latch_set |=> ((status_r & $past(latch_set)) == $past(latch_set)))
		else $error("detected event not latched");

	edge_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		(pin_event & ~(rise_en | fall_en)) == 16'h0000)
		else $error("event on pin with detection off");

	input_only_a: assert property (@(posedge sys_clk) disable iff (rst)
		(pin_event & ~pin_is_input) == 16'h0000)
		else $error("event on non-input pin");

	reserved_inert_a: assert property (@(posedge sys_clk) disable iff (rst)
		(status_r & ~PIN_VALID) == 16'h0000)
		else $error("reserved status bit set");

	masked_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
		((status_r & ~mask_all) == 16'h0000) |=> proc1_irq_n)
		else $error("request with all status masked");

	unmasked_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
		(|(status_r & ~mask_all)) |=> !proc1_irq_n)
		else $error("unmasked status without request");

	pend_discard_a: assert property (@(posedge sys_clk) disable iff (rst)
		(pending_event_disable_r && !proc1_irq_n) |-> (latch_set == 16'h0000))
		else $error("event kept during service");

	read_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		(reg_rd && !reg_wr && !clear_on_read_select_r)
		|=> (status_r == ($past(status_r) | $past(latch_set))))
		else $error("read changed status in write-clear mode");

	write_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_status_lo && !clear_on_read_select_r && (latch_set[7:0] == 8'h00))
		|=> ((status_r[7:0] & $past(reg_wdata)) == 8'h00))
		else $error("write did not clear status bits");

	read_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_status_lo && clear_on_read_select_r && (latch_set[7:0] == 8'h00))
		|=> (status_r[7:0] == 8'h00))
		else $error("read did not clear status");

	read_release_a: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_status_lo && clear_on_read_select_r && (latch_set == 16'h0000)
		&& ((status_r[15:8] & ~mask_r[1]) == 8'h00))
		##1 (latch_set == 16'h0000) |=> proc1_irq_n)
		else $error("request held after clearing read");

	ctrl_reserved_a: assert property (@(posedge sys_clk) disable iff (rst)
		(reg_rd && (reg_addr == OFS_CTRL)) |=> ((reg_rdata & 8'hF9) == 8'h00))
		else $error("reserved control bits not zero");

	irq_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
		$fell(proc1_irq_n));
	read_clear_c: cover property (@(posedge sys_clk) disable iff (rst)
		rd_status_lo && clear_on_read_select_r && (status_r[7:0] != 8'h00));
	both_edges_c: cover property (@(posedge sys_clk) disable iff (rst)
		pin_event[0] && rise_en[0] && fall_en[0]);
	pend_drop_c: cover property (@(posedge sys_clk) disable iff (rst)
		pending_event_disable_r && !proc1_irq_n && |(pin_event & PIN_VALID));
endmodule : edge_irq_handler

// ===== tb/host_model.sv
// host side: register accesses into the block
`timescale 1ns/1ps
module host_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata
);
	// ========
	// access tasks, launched just after an edge
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'h0;
		reg_rd    = 1'h0;
		reg_wdata = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'h1;
		@(posedge sys_clk);
		#1;
		reg_wr    = 1'h0;
		// stale data must not look valid
		reg_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_rd   = 1'h1;
		@(posedge sys_clk);
		#1;
		reg_rd   = 1'h0;
		d        = reg_rdata;
	endtask : rd
endmodule : host_model

// ===== tb/edge_irq_handler_tb_top.sv
// testbench for the pin edge interrupt handler
`timescale 1ns/1ps
module edge_irq_handler_tb_top
	import edge_irq_pkg::*;
;
	logic        sys_clk;
	logic        rst;
	logic [15:0] pin_in;
	logic [15:0] pin_is_input;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        proc1_irq_n;
	logic [7:0]  rv;
	int          bad_count;
	int          cmp_count;

	edge_irq_handler edge_irq_handler_inst (.sys_clk(sys_clk), .rst(rst), .pin_in(pin_in),
		.pin_is_input(pin_is_input), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .proc1_irq_n(proc1_irq_n));
	host_model host_model_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

	// ========
	// helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host_model_inst.rd(a, rv);
		chk(rv, exp);
	endtask : rdchk

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	// one pin: select pattern, rise then fall, status seen without clearing on read
	task automatic edge_case(input int p, input logic [1:0] sel, input logic e_r, input logic e_f);
		logic [7:0] sa;
		logic [7:0] bv;
		sa = OFS_STATUS_LO + 8'(p / 8);
		bv = 8'h01 << (p % 8);
		host_model_inst.wr(OFS_EDGE_0_3 + 8'(p / 4), 8'({6'h00, sel} << (2 * (p % 4))));
		pin_in[p] = 1'h1;
		step(8);
		rdchk(sa, e_r ? bv : 8'h00);
		host_model_inst.wr(sa, 8'hFF);
		pin_in[p] = 1'h0;
		step(8);
		rdchk(sa, e_f ? bv : 8'h00);
		host_model_inst.wr(sa, 8'hFF);
		host_model_inst.wr(OFS_EDGE_0_3 + 8'(p / 4), 8'h00);
	endtask : edge_case

	task automatic irq_case();
		host_model_inst.wr(OFS_EDGE_0_3, 8'h02);
		pin_in[0] = 1'h1;
		step(8);
		chk({7'h00, proc1_irq_n}, 8'h01);
		rdchk(OFS_STATUS_LO, 8'h01);
		rdchk(OFS_STATUS_LO, 8'h01);
		host_model_inst.wr(OFS_MASK_LO, 8'hFE);
		step(2);
		chk({7'h00, proc1_irq_n}, 8'h00);
		host_model_inst.wr(OFS_CTRL, 8'h04);
		rdchk(OFS_STATUS_LO, 8'h01);
		step(1);
		chk({7'h00, proc1_irq_n}, 8'h01);
		rdchk(OFS_STATUS_LO, 8'h00);
	endtask : irq_case

	// events during service: dropped when disabled, kept otherwise
	task automatic pend_case();
		pin_in[1] = 1'h1;
		host_model_inst.wr(OFS_CTRL, 8'h02);
		host_model_inst.wr(OFS_EDGE_0_3, 8'h06);
		pin_in[0] = 1'h0;
		step(8);
		pin_in[0] = 1'h1;
		step(8);
		pin_in[1] = 1'h0;
		step(8);
		rdchk(OFS_STATUS_LO, 8'h01);
		host_model_inst.wr(OFS_CTRL, 8'h00);
		pin_in[1] = 1'h1;
		step(8);
		pin_in[1] = 1'h0;
		step(8);
		rdchk(OFS_STATUS_LO, 8'h03);
		// partial write: only the addressed bit may clear
		host_model_inst.wr(OFS_STATUS_LO, 8'h01);
		rdchk(OFS_STATUS_LO, 8'h02);
	endtask : pend_case

	task automatic give_verdict();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	// ========
	// clock, watchdog, main sequence
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	// whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		give_verdict();
	end

	initial begin
		bad_count    = 0;
		cmp_count    = 0;
		rst          = 1'h1;
		pin_in       = 16'h0000;
		pin_is_input = 16'hFFFF;
		step(10);
		rst = 1'h0;
		for (int i = 0; i < 4; i++) begin
			rdchk(OFS_EDGE_0_3 + 8'(i), 8'h00);
		end
		rdchk(OFS_MASK_LO, 8'hFF);
		rdchk(OFS_MASK_HI, 8'hFF);
		rdchk(OFS_STATUS_HI, 8'h00);
		rdchk(8'h10, 8'h00);
		rdchk(OFS_CTRL, 8'h00);
		host_model_inst.wr(OFS_CTRL, 8'hFF);
		rdchk(OFS_CTRL, 8'h06);
		host_model_inst.wr(OFS_CTRL, 8'h00);
		edge_case(0, 2'h2, 1'h1, 1'h0);
		edge_case(1, 2'h1, 1'h0, 1'h1);
		edge_case(9, 2'h3, 1'h1, 1'h1);
		edge_case(14, 2'h3, 1'h1, 1'h1);
		edge_case(2, 2'h0, 1'h0, 1'h0);
		edge_case(6, 2'h3, 1'h0, 1'h0);
		pin_is_input[3] = 1'h0;
		edge_case(3, 2'h3, 1'h0, 1'h0);
		pin_is_input[3] = 1'h1;
		irq_case();
		pend_case();
		give_verdict();
	end
endmodule : edge_irq_handler_tb_top
